// ===== logic/hdtc_pkg.sv
// constants for the hypervisor debug and coprocessor trap control bank
package hdtc_pkg;
    // coprocessor move encoding of the debug control register
    localparam logic [2:0] HDC_OPC1 = 3'h4;
    localparam logic [3:0] HDC_CRN  = 4'h1;
    localparam logic [3:0] HDC_CRM  = 4'h1;
    localparam logic [2:0] HDC_OPC2 = 3'h1;
    // coprocessor trap register shares opc1/crn/crm, opc2 differs
    localparam logic [2:0] CPT_OPC2 = 3'h2;
    // coprocessor numbers of the debug and system coprocessors
    localparam logic [3:0] CP_DEBUG  = 4'he;
    localparam logic [3:0] CP_SYSTEM = 4'hf;
    // debug control field positions
    localparam int HDC_PART_LSB = 0;
    localparam int HDC_PART_W   = 5;
    localparam int HDC_MCTRL    = 5;
    localparam int HDC_PMTRAP   = 6;
    localparam int HDC_HPCE     = 7;
    localparam int HDC_DBGEXC   = 8;
    localparam int HDC_DREGACC  = 9;
    localparam int HDC_OSDBG    = 10;
    localparam int HDC_DROM     = 11;
    // coprocessor trap field positions
    localparam int CPT_CP_W     = 14;
    localparam int CPT_VEC      = 15;
    localparam int CPT_CPAC     = 31;
    localparam logic [31:0] CPT_WMASK = 32'h8000_bfff;
    // reset values
    localparam logic [4:0]  PART_RST  = 5'h4;
    localparam logic [31:0] CPT_RST   = 32'h0000_0000;
    // privilege levels
    localparam logic [1:0] PL_ZERO = 2'h0;
    localparam logic [1:0] PL_ONE  = 2'h1;
    localparam logic [1:0] PL_TWO  = 2'h2;
endpackage

// ===== logic/hdtc_ctrl.sv
// hypervisor debug control and coprocessor trap register bank
`timescale 1ns/1ps
module hdtc_ctrl #(
    parameter int CTR_COUNT = 4
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // current execution state
    input  wire logic [1:0]  cur_pl,
    input  wire logic        cur_nonsecure,
    input  wire logic        cur_monitor,
    input  wire logic        secure_config_nonsecure_bit,
    input  wire logic [15:0] nonsecure_access_control,
    input  wire logic        ctr_user_en,
    // coprocessor move port
    input  wire logic        cp_valid,
    input  wire logic        cp_write,
    input  wire logic [2:0]  cp_opc1,
    input  wire logic [3:0]  cp_crn,
    input  wire logic [3:0]  cp_crm,
    input  wire logic [2:0]  cp_opc2,
    input  wire logic [31:0] cp_wdata,
    output logic             cp_done,
    output logic             cp_undef,
    output logic [31:0]      cp_rdata,
    // use of other coprocessors and vector unit
    input  wire logic        cop_req,
    input  wire logic [3:0]  cop_num,
    input  wire logic        cop_vector,
    input  wire logic        cop_cpac,
    // monitor register and counter accesses
    input  wire logic        mon_req,
    input  wire logic        mon_ctrl,
    input  wire logic        ctr_req,
    input  wire logic [4:0]  ctr_idx,
    // debug exception
    input  wire logic        dbg_exc,
    // outcomes
    output logic             hyp_trap,
    output logic             acc_undef,
    output logic             acc_grant,
    output logic             ctr_enabled
);
    // debug control bits and coprocessor trap register
    logic [11:0] hdc_reg, hdc_next;
    logic [31:0] cpt_reg, cpt_next;
    logic        hpce_reg, hpce_next;
    logic        done_reg, done_next;
    logic        undef_reg, undef_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        trap_reg, trap_next;
    logic        aund_reg, aund_next;
    logic        grant_reg, grant_next;
    logic [31:0] cpt_view;
    logic        is_hdc, is_cpt, reg_ok, ns_low;

    function automatic logic enc_hit(input logic [2:0] o1,
                                     input logic [3:0] n,
                                     input logic [3:0] m);
        enc_hit = o1 == hdtc_pkg::HDC_OPC1 && n == hdtc_pkg::HDC_CRN
                  && m == hdtc_pkg::HDC_CRM;
    endfunction

    // bits forbidden by access control read as one for non-secure callers
    always_comb
    begin
        cpt_view = cpt_reg;
        if (cur_nonsecure)
        begin
            cpt_view[hdtc_pkg::CPT_CP_W-1:0] = cpt_reg[13:0]
                | ~nonsecure_access_control[13:0];
            cpt_view[hdtc_pkg::CPT_VEC] = cpt_reg[hdtc_pkg::CPT_VEC]
                | ~nonsecure_access_control[15];
        end
    end

    assign is_hdc = enc_hit(cp_opc1, cp_crn, cp_crm)
                    && cp_opc2 == hdtc_pkg::HDC_OPC2;
    assign is_cpt = enc_hit(cp_opc1, cp_crn, cp_crm)
                    && cp_opc2 == hdtc_pkg::CPT_OPC2;
    assign reg_ok = cur_pl == hdtc_pkg::PL_TWO
                    || (cur_monitor && secure_config_nonsecure_bit);
    assign ns_low = cur_nonsecure && cur_pl != hdtc_pkg::PL_TWO;

    // register access path
    always_comb
    begin
        hdc_next   = hdc_reg;
        cpt_next   = cpt_reg;
        hpce_next  = hpce_reg;
        done_next  = cp_valid;
        undef_next = 1'b0;
        rdata_next = rdata_reg;
        if (cp_valid)
        begin
            if (!(is_hdc || is_cpt) || !reg_ok)
                undef_next = 1'b1;
            else if (cp_write && is_hdc)
            begin
                // bit 7 is served from hpce_reg, this copy is never read
                hdc_next  = cp_wdata[11:0];
                hpce_next = cp_wdata[hdtc_pkg::HDC_HPCE];
            end
            else if (cp_write)
            begin
                cpt_next = cp_wdata & hdtc_pkg::CPT_WMASK;
                if (cur_nonsecure)
                begin
                    // forbidden bits keep their stored value
                    cpt_next[13:0] = (cp_wdata[13:0]
                        & nonsecure_access_control[13:0])
                        | (cpt_reg[13:0]
                        & ~nonsecure_access_control[13:0]);
                    cpt_next[15] = nonsecure_access_control[15]
                        ? cp_wdata[15] : cpt_reg[15];
                end
            end
            else if (is_hdc)
                rdata_next = {20'h0_0000, hdc_reg[11:8], hpce_reg,
                              hdc_reg[6:0]};
            else
                rdata_next = cpt_view;
        end
    end

    // outcome of coprocessor, monitor, counter and debug events
    always_comb
    begin
        trap_next  = 1'b0;
        aund_next  = 1'b0;
        grant_next = 1'b0;
        if (dbg_exc)
        begin
            // caught exception is redirected rather than taken locally
            trap_next = cur_nonsecure && hdc_reg[hdtc_pkg::HDC_DBGEXC];
            grant_next = !trap_next;
        end
        else if (cop_req)
        begin
            if (cop_num == hdtc_pkg::CP_DEBUG
                || cop_num == hdtc_pkg::CP_SYSTEM)
                grant_next = 1'b1;
            else if (cur_nonsecure && cur_pl == hdtc_pkg::PL_TWO)
            begin
                // access control in cpt_view wins, cop_cpac ignored here
                aund_next = cop_vector ? cpt_view[hdtc_pkg::CPT_VEC]
                          : cpt_view[cop_num];
                grant_next = !aund_next;
            end
            else if (ns_low)
            begin
                trap_next = cop_cpac ? cpt_reg[hdtc_pkg::CPT_CPAC]
                          : (cpt_view[cop_num]
                          || (cop_vector && cpt_view[15]));
                grant_next = !trap_next;
            end
            else
                grant_next = 1'b1;
        end
        else if (mon_req)
        begin
            trap_next = ns_low && (mon_ctrl
                ? hdc_reg[hdtc_pkg::HDC_MCTRL]
                : hdc_reg[hdtc_pkg::HDC_PMTRAP]);
            grant_next = !trap_next;
        end
        else if (ctr_req)
        begin
            if (!cur_nonsecure)
                grant_next = ctr_idx < 5'(CTR_COUNT);
            else if (ctr_idx < hdc_reg[4:0])
                grant_next = cur_pl != hdtc_pkg::PL_ZERO
                             || ctr_user_en;
            else if (ctr_idx < 5'(CTR_COUNT))
                grant_next = cur_pl == hdtc_pkg::PL_TWO && hpce_reg;
            aund_next = !grant_next;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            hdc_reg   <= {7'h00, hdtc_pkg::PART_RST};
            cpt_reg   <= hdtc_pkg::CPT_RST;
            done_reg  <= 1'b0;
            undef_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            trap_reg  <= 1'b0;
            aund_reg  <= 1'b0;
            grant_reg <= 1'b0;
        end
        else
        begin
            hdc_reg   <= hdc_next;
            cpt_reg   <= cpt_next;
            done_reg  <= done_next;
            undef_reg <= undef_next;
            rdata_reg <= rdata_next;
            trap_reg  <= trap_next;
            aund_reg  <= aund_next;
            grant_reg <= grant_next;
        end
    end

    // counter enable keeps no reset on purpose: its value is undefined
    always_ff @(posedge mclk)
    begin
        hpce_reg <= hpce_next;
    end

    assign cp_done     = done_reg;
    assign cp_undef    = undef_reg;
    assign cp_rdata    = rdata_reg;
    assign hyp_trap    = trap_reg;
    assign acc_undef   = aund_reg;
    assign acc_grant   = grant_reg;
    assign ctr_enabled = hpce_reg;

    a_dbg_redirect: assert property (@(posedge mclk) disable iff (rst)
        dbg_exc && cur_nonsecure && hdc_reg[8] |=> hyp_trap && !acc_grant)
        else $error("debug exception not redirected");
    a_reset_values: assert property (@(posedge mclk)
        $fell(rst) |-> hdc_reg[4:0] == 5'h4 && !hdc_reg[8] && !hdc_reg[5])
        else $error("wrong reset value");
    a_hpce_write: assert property (@(posedge mclk) disable iff (rst)
        cp_valid && cp_write && is_hdc && reg_ok
        |=> ctr_enabled == $past(cp_wdata[7]))
        else $error("counter enable not written");
    a_pm_trap: assert property (@(posedge mclk) disable iff (rst)
        mon_req && !cop_req && !dbg_exc && ns_low && !mon_ctrl
        && hdc_reg[6] |=> hyp_trap)
        else $error("monitor access not trapped");
    a_mctrl_trap: assert property (@(posedge mclk) disable iff (rst)
        mon_req && !cop_req && !dbg_exc && ns_low && mon_ctrl
        |=> hyp_trap == $past(hdc_reg[5]))
        else $error("control access trap wrong");
    a_low_ctr: assert property (@(posedge mclk) disable iff (rst)
        ctr_req && !mon_req && !cop_req && !dbg_exc && cur_nonsecure
        && ctr_idx < hdc_reg[4:0] && cur_pl == 2'h1 |=> acc_grant)
        else $error("low counter refused");
    a_high_ctr: assert property (@(posedge mclk) disable iff (rst)
        ctr_req && !mon_req && !cop_req && !dbg_exc && cur_nonsecure
        && ctr_idx >= hdc_reg[4:0] && cur_pl != 2'h2 |=> !acc_grant)
        else $error("high counter granted below level 2");
    a_cpt_guard: assert property (@(posedge mclk) disable iff (rst)
        cp_valid && is_cpt && !reg_ok
        |=> cp_undef && cpt_reg == $past(cpt_reg))
        else $error("trap register reached illegally");
    a_cop_exempt: assert property (@(posedge mclk) disable iff (rst)
        cop_req && !dbg_exc && cop_num == 4'hf |=> acc_grant && !hyp_trap)
        else $error("system coprocessor trapped");
    a_nsac_ro: assert property (@(posedge mclk) disable iff (rst)
        cp_valid && !cp_write && is_cpt && reg_ok && cur_nonsecure
        && !nonsecure_access_control[10] |=> cp_rdata[10])
        else $error("forbidden bit not read as one");

    c_dbg_trap: cover property (@(posedge mclk) disable iff (rst)
        dbg_exc && cur_nonsecure && hdc_reg[8] ##1 hyp_trap);
    c_cop_trap: cover property (@(posedge mclk) disable iff (rst)
        cop_req && ns_low ##1 hyp_trap);
    c_hdc_read: cover property (@(posedge mclk) disable iff (rst)
        cp_valid && !cp_write && is_hdc ##1 cp_done && !cp_undef);
endmodule

// ===== dv/tb_hyp_debug_and_coproc_trap_control.sv
// self-checking bench for the hypervisor trap control bank
`timescale 1ns/1ps
module tb_hyp_debug_and_coproc_trap_control;
    typedef struct {
        logic        ev;
        logic [2:0]  code;
        logic [31:0] d;
        logic [31:0] m;
    } hdtc_note_t;
    logic        mclk, rst, cur_nonsecure, cur_monitor, ctr_user_en;
    logic        secure_config_nonsecure_bit, cp_valid, cp_write;
    logic        cop_req, cop_vector, cop_cpac, mon_req, mon_ctrl;
    logic        ctr_req, dbg_exc, cp_done, cp_undef, hyp_trap;
    logic        acc_undef, acc_grant, ctr_enabled;
    logic [1:0]  cur_pl;
    logic [2:0]  cp_opc1, cp_opc2;
    logic [3:0]  cp_crn, cp_crm, cop_num;
    logic [4:0]  ctr_idx;
    logic [15:0] nonsecure_access_control;
    logic [31:0] cp_wdata, cp_rdata, seed, v;
    int          error_cnt, checks;
    hdtc_note_t  q[$];

    hdtc_ctrl #(.CTR_COUNT(4)) uut (
        .mclk, .rst, .cur_pl, .cur_nonsecure, .cur_monitor,
        .secure_config_nonsecure_bit, .nonsecure_access_control,
        .ctr_user_en, .cp_valid, .cp_write, .cp_opc1, .cp_crn, .cp_crm,
        .cp_opc2, .cp_wdata, .cp_done, .cp_undef, .cp_rdata, .cop_req,
        .cop_num, .cop_vector, .cop_cpac, .mon_req, .mon_ctrl, .ctr_req,
        .ctr_idx, .dbg_exc, .hyp_trap, .acc_undef, .acc_grant,
        .ctr_enabled);

    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic cmp(string nm, logic [31:0] e, logic [31:0] s);
        checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    task end_sim;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // each task clears the other port's strobes so cp and event requests never overlap
    task automatic cp(logic w, logic [2:0] o2, logic [31:0] wd, logic u,
                      logic [31:0] d, logic [31:0] m);
        q.push_back('{1'b0, {2'b00, u}, d, m});
        {dbg_exc, cop_req, mon_req, ctr_req} = 4'h0;
        cp_valid = 1'b1;
        cp_write = w;
        cp_opc2  = o2;
        cp_wdata = wd;
        @(negedge mclk);
    endtask

    task automatic ev(logic [3:0] r, logic [4:0] a, logic [2:0] e);
        q.push_back('{1'b1, e, 32'h0, 32'h0});
        cp_valid = 1'b0;
        {dbg_exc, cop_req, mon_req, ctr_req} = r;
        cop_num = a[3:0];
        ctr_idx = a;
        @(negedge mclk);
    endtask

    // outcomes are one-cycle pulses, so they are looked at once, settled
    always @(negedge mclk)
    begin
        if (cp_done === 1'b1 || {hyp_trap, acc_undef, acc_grant} !== 3'h0)
        begin
            if (q.size() == 0)
                cmp("unexpected result", 32'h0, 32'h1);
            else if (q[0].ev)
                cmp("event", q[0].code, {hyp_trap, acc_undef, acc_grant});
            else
            begin
                cmp("cp_undef", q[0].code, cp_undef);
                cmp("cp_rdata", q[0].d, cp_rdata & q[0].m);
            end
            if (q.size() != 0)
                q.pop_front();
        end
    end

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial
    begin
        #(3000 * 100);
        error_cnt++;
        end_sim();
    end

    initial
    begin
        {rst, cp_valid, cp_write, cop_req, cop_vector, cop_cpac} = 6'h20;
        {mon_req, mon_ctrl, ctr_req, dbg_exc, cur_monitor} = 5'h0;
        {secure_config_nonsecure_bit, ctr_user_en} = 2'h0;
        {cur_nonsecure, cur_pl, nonsecure_access_control} = 19'h6ffff;
        {cop_num, ctr_idx, cp_wdata, cp_opc2} = 0;
        cp_opc1 = hdtc_pkg::HDC_OPC1;
        cp_crn  = hdtc_pkg::HDC_CRN;
        cp_crm  = hdtc_pkg::HDC_CRM;
        seed    = 32'h0000_003c;
        error_cnt = 0;
        checks    = 0;
        repeat (12) @(negedge mclk);
        rst = 1'b0;
        cp(0, hdtc_pkg::HDC_OPC2, 0, 0, 32'h4, 32'hffff_ff7f);
        cp(0, hdtc_pkg::CPT_OPC2, 0, 0, 0, 32'hffff_ffff);
        cp(0, 3'h3, 0, 1, 0, 0);
        cur_pl = hdtc_pkg::PL_ONE;
        cp(1, hdtc_pkg::HDC_OPC2, 32'hfff, 1, 0, 0);
        {cur_monitor, secure_config_nonsecure_bit, cur_nonsecure} = 3'h6;
        cp(0, hdtc_pkg::CPT_OPC2, 0, 0, 0, 32'hffff_ffff);
        secure_config_nonsecure_bit = 1'b0;
        cp(0, hdtc_pkg::CPT_OPC2, 0, 1, 0, 0);
        {cur_monitor, cur_nonsecure, cur_pl} = 4'h2;
        cp(0, hdtc_pkg::HDC_OPC2, 0, 0, 32'h4, 32'hffff_ff7f);
        repeat (6)
        begin
            v = next_rand();
            if (v[4:0] > 5'h4)
                v[4:0] = 5'h4;
            if (v[8])
                v[11:9] = 3'h7;
            cp(1, hdtc_pkg::HDC_OPC2, v, 0, 0, 0);
            cmp("ctr_enabled", {31'h0, v[7]}, {31'h0, ctr_enabled});
            cp(0, hdtc_pkg::HDC_OPC2, 0, 0, v & 32'hfff, '1);
            v = next_rand();
            cp(1, hdtc_pkg::CPT_OPC2, v, 0, 0, 0);
            cp(0, hdtc_pkg::CPT_OPC2, 0, 0,
               v & hdtc_pkg::CPT_WMASK, '1);
        end
        cur_nonsecure = 1'b1;
        nonsecure_access_control = 16'hfbff;
        cp(0, hdtc_pkg::CPT_OPC2, 0, 0, 32'h400, 32'h400);
        nonsecure_access_control = 16'hffff;
        cp(1, hdtc_pkg::HDC_OPC2, 32'hf62, 0, 0, 0);
        cp(1, hdtc_pkg::CPT_OPC2, 32'h8400, 0, 0, 0);
        cur_pl = hdtc_pkg::PL_ONE;
        ev(4'b1001, 5'h1, 3'b100);
        ev(4'b0010, 5'h0, 3'b100);
        mon_ctrl = 1'b1;
        ev(4'b0010, 5'h0, 3'b100);
        ev(4'b0100, 5'ha, 3'b100);
        ev(4'b0100, 5'he, 3'b001);
        ev(4'b0100, 5'hf, 3'b001);
        cop_vector = 1'b1;
        ev(4'b0100, 5'h2, 3'b100);
        cop_vector = 1'b0;
        ev(4'b0001, 5'h1, 3'b001);
        ev(4'b0001, 5'h2, 3'b010);
        cur_pl = hdtc_pkg::PL_ZERO;
        ev(4'b0001, 5'h1, 3'b010);
        ctr_user_en = 1'b1;
        ev(4'b0001, 5'h1, 3'b001);
        cur_pl = hdtc_pkg::PL_TWO;
        ev(4'b0001, 5'h2, 3'b010);
        ev(4'b0100, 5'ha, 3'b010);
        cp(1, hdtc_pkg::HDC_OPC2, 32'h82, 0, 0, 0);
        cp(1, hdtc_pkg::CPT_OPC2, 32'h0, 0, 0, 0);
        ev(4'b0001, 5'h2, 3'b001);
        ev(4'b0001, 5'h4, 3'b010);
        ev(4'b0100, 5'ha, 3'b001);
        nonsecure_access_control = 16'hfbff;
        ev(4'b0100, 5'ha, 3'b010);
        cur_pl = hdtc_pkg::PL_ONE;
        ev(4'b1000, 5'h0, 3'b001);
        ev(4'b0010, 5'h0, 3'b001);
        cur_pl = hdtc_pkg::PL_TWO;
        cp(1, hdtc_pkg::CPT_OPC2, 32'h8000_0000, 0, 0, 0);
        cp(0, hdtc_pkg::CPT_OPC2, 0, 0, 32'h8000_0400, '1);
        cur_pl = hdtc_pkg::PL_ONE;
        cop_cpac = 1'b1;
        ev(4'b0100, 5'h0, 3'b100);
        cop_cpac = 1'b0;
        cp_valid = 1'b0;
        {dbg_exc, cop_req, mon_req, ctr_req} = 4'h0;
        repeat (3) @(negedge mclk);
        if (q.size() != 0)
            cmp("pending results", 32'h0, q.size());
        end_sim();
    end
endmodule
